// ---- src/sodm_pkg.sv ----
// Shared constants and types for the safety output delay and monitor block
package sodm_pkg;
	localparam int unsigned NUM_PAIRS = 2;
	localparam int unsigned NUM_CHAN = 4;
	localparam int unsigned MS_W = 19;
	// Clock and timing figures
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned MS_IN_PS = 1000000000;
	localparam int unsigned CYC_PER_MS = MS_IN_PS / CLK_PERIOD_PS;
	localparam int unsigned TICK_W = 17;
	localparam logic [MS_W-1:0] DELAY_MIN_MS = 19'h00064;
	localparam int unsigned DELAY_MAX_MIN = 5;
	localparam logic [MS_W-1:0] DELAY_MAX_MS = MS_W'(DELAY_MAX_MIN * 60 * 1000);
	// Readback settle time before a mismatch counts
	localparam logic [3:0] SETTLE_MS = 4'h5;
	// Linked pair: leader output index and follower output index
	localparam int unsigned LINK_LEADER = 0;
	localparam int unsigned LINK_FOLLOWER = 2;

	typedef enum logic [1:0] {
		DLY_NONE = 2'h0,
		DLY_ON = 2'h1,
		DLY_OFF = 2'h2
	} sodm_delay_t;

	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_ON_WAIT = 4'h2,
		ST_ON = 4'h4,
		ST_OFF_WAIT = 4'h8
	} sodm_state_t;

	typedef struct packed {
		sodm_delay_t dly;
		logic [MS_W-1:0] ms;
	} sodm_out_cfg_t;
endpackage : sodm_pkg

// ---- src/sodm_top.sv ----
// Safety output control: split, delays, linking, short monitoring, relay group
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Split exists only for solid-state pairs; pairs are dual-channel unless split.
// R2: Split channels run independently; one never affects its former partner.
// R3: An output carries one delay type only: none, on-delay or off-delay.
// R4: Delayed change to On or Off happens only after full delay time.
// R5: Delay spans 100 ms to 5 minutes in 1 ms steps.
// R6: A started off-delay always runs out, then the output goes Off.
// R7: Linking allowed only between an off-delayed and a non-delayed output.
// R8: Linked non-delayed output stays Off while the leader off-delay runs.
// R9: Paired solid-state channels are checked continuously for shorts.
// R10: Fault on either channel of a pair: both Off and lockout.
// R11: Split channel still monitored, but no corrective switching is done.
// R12: Readback above 1.7 V after Off command means still on: lockout.
// R13: Relay outputs of a module switch as one group, never split.
// R14: Relay outputs are driven and monitored internally, no external feedback.
// R15: On-delay abandoned and output kept Off if input returns to Stop.
module sodm_top #(
	parameter int unsigned CYC_PER_MS = sodm_pkg::CYC_PER_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [sodm_pkg::NUM_CHAN-1:0] i_run,
	input wire logic [sodm_pkg::NUM_PAIRS-1:0] i_split,
	input wire sodm_pkg::sodm_out_cfg_t [sodm_pkg::NUM_CHAN-1:0] i_out_cfg,
	input wire logic i_link_en,
	input wire logic [sodm_pkg::NUM_CHAN-1:0] i_readback_high,
	input wire logic i_relay_run,
	input wire logic i_relay_readback,
	output logic [sodm_pkg::NUM_CHAN-1:0] o_solid_out,
	output logic [sodm_pkg::NUM_CHAN-1:0] o_chan_fault,
	output logic [sodm_pkg::NUM_PAIRS-1:0] o_pair_lockout,
	output logic o_link_active,
	output logic o_module_relay_out,
	output logic o_relay_lockout
);
	localparam int unsigned NRB = sodm_pkg::NUM_CHAN + 1;

	// Readback pins: three stages, a change counts once stages two and three agree
	logic [NRB-1:0] rb_s1;
	logic [NRB-1:0] rb_s2;
	logic [NRB-1:0] rb_s3;
	logic [NRB-1:0] rb;
	wire [NRB-1:0] rb_raw = {i_relay_readback, i_readback_high};
	// Disagreeing stages hold the filter, so one glitch never counts
	wire [NRB-1:0] next_rb = (rb_s2 & rb_s3) | (rb & (rb_s2 | rb_s3));
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rb_s1 <= '0;
		end else begin
			rb_s1 <= rb_raw;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rb_s2 <= '0;
		end else begin
			rb_s2 <= rb_s1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rb_s3 <= '0;
		end else begin
			rb_s3 <= rb_s2;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rb <= '0;
		end else begin
			rb <= next_rb;
		end
	end

	// Millisecond tick shared by all timers
	logic [sodm_pkg::TICK_W-1:0] tick_cnt;
	wire tick = (tick_cnt == sodm_pkg::TICK_W'(CYC_PER_MS - 1));
	// Free-running, so the first delay tick may come early: one extra tick is waited
	wire [sodm_pkg::TICK_W-1:0] tick_inc = tick_cnt + 1'b1;
	wire [sodm_pkg::TICK_W-1:0] next_tick = tick ? '0 : tick_inc;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= next_tick;
		end
	end

	// Configuration checks
	sodm_pkg::sodm_delay_t dly_ok [sodm_pkg::NUM_CHAN];
	logic [sodm_pkg::MS_W-1:0] lim_ms [sodm_pkg::NUM_CHAN];
	sodm_pkg::sodm_state_t state [sodm_pkg::NUM_CHAN];
	logic [sodm_pkg::NUM_CHAN-1:0] chan_lock;
	logic [sodm_pkg::NUM_CHAN-1:0] fb_bad;
	logic link_on;
	sodm_pkg::sodm_state_t next_st [sodm_pkg::NUM_CHAN];

	// R7: link legality
	assign link_on = i_link_en && (dly_ok[sodm_pkg::LINK_LEADER] == sodm_pkg::DLY_OFF)
		&& (dly_ok[sodm_pkg::LINK_FOLLOWER] == sodm_pkg::DLY_NONE);

	genvar c;
	generate
		for (c = 0; c < sodm_pkg::NUM_CHAN; c++) begin : g_chan
			localparam int unsigned PAIR = c / 2;
			// R1: paired b channel follows channel a
			wire paired_b = (c % 2 == 1) && !i_split[PAIR];
			localparam int unsigned MATE = c - (c % 2);
			wire [1:0] src = paired_b ? 2'(MATE) : 2'(c);
			// R3: one delay type, illegal code means none
			assign dly_ok[c] = (i_out_cfg[c].dly == sodm_pkg::DLY_ON) ? sodm_pkg::DLY_ON :
				(i_out_cfg[c].dly == sodm_pkg::DLY_OFF) ? sodm_pkg::DLY_OFF :
				sodm_pkg::DLY_NONE;
			// R5: clamp delay to legal span
			// Out-of-range values clamp rather than reject, so an output is never left undelayed
			wire ms_low = (i_out_cfg[c].ms < sodm_pkg::DELAY_MIN_MS);
			wire ms_high = (i_out_cfg[c].ms > sodm_pkg::DELAY_MAX_MS);
			wire [sodm_pkg::MS_W-1:0] ms_top = ms_high ? sodm_pkg::DELAY_MAX_MS : i_out_cfg[c].ms;
			assign lim_ms[c] = ms_low ? sodm_pkg::DELAY_MIN_MS : ms_top;
			wire sodm_pkg::sodm_delay_t my_dly = dly_ok[src];
			wire [sodm_pkg::MS_W-1:0] my_lim = lim_ms[src];
			// R8: follower held Off while the leader off-delay runs
			wire hold = link_on && (src == 2'(sodm_pkg::LINK_FOLLOWER))
				&& (state[sodm_pkg::LINK_LEADER] == sodm_pkg::ST_OFF_WAIT);
			// R2: each split channel uses only its own input
			wire run_g = i_run[src] && !hold;

			logic [sodm_pkg::MS_W-1:0] cnt;
			// R4: done only after the full count; first tick may be partial
			wire done = tick && (cnt >= my_lim);
			sodm_pkg::sodm_state_t next_state;
			always_comb begin
				next_state = state[c];
				unique case (state[c])
					sodm_pkg::ST_OFF: begin
						if (run_g) begin
							next_state = (my_dly == sodm_pkg::DLY_ON) ? sodm_pkg::ST_ON_WAIT :
								sodm_pkg::ST_ON;
						end
					end
					sodm_pkg::ST_ON_WAIT: begin
						// R15: stop abandons the on-delay
						if (!run_g) begin
							next_state = sodm_pkg::ST_OFF;
						end else if (done) begin
							next_state = sodm_pkg::ST_ON;
						end
					end
					sodm_pkg::ST_ON: begin
						if (!run_g) begin
							next_state = (my_dly == sodm_pkg::DLY_OFF) ? sodm_pkg::ST_OFF_WAIT :
								sodm_pkg::ST_OFF;
						end
					end
					sodm_pkg::ST_OFF_WAIT: begin
						// R6: return to run is ignored until expiry
						if (done) begin
							next_state = sodm_pkg::ST_OFF;
						end
					end
					default: next_state = sodm_pkg::ST_OFF;
				endcase
				// R10: lockout forces the channel Off
				if (chan_lock[c]) begin
					next_state = sodm_pkg::ST_OFF;
				end
			end
			// R1: paired b takes its mate's next state, so the pair never drifts apart
			sodm_pkg::sodm_state_t next_sel;
			assign next_st[c] = next_state;
			assign next_sel = paired_b ? next_st[MATE] : next_state;
			wire next_drive = (next_sel == sodm_pkg::ST_ON) || (next_sel == sodm_pkg::ST_OFF_WAIT);
			wire waiting = (state[c] == sodm_pkg::ST_ON_WAIT) || (state[c] == sodm_pkg::ST_OFF_WAIT);

			// Readback settle timer restarts on every drive change
			logic [3:0] settle;
			wire settled = (settle == sodm_pkg::SETTLE_MS);
			// R9: readback must match the command once settled
			// R12: high readback while commanded Off is a fault
			assign fb_bad[c] = settled && (rb[c] != o_solid_out[c]);

			wire state_change = (next_sel != state[c]);
			wire [sodm_pkg::MS_W-1:0] cnt_inc = cnt + 1'b1;
			wire [sodm_pkg::MS_W-1:0] cnt_run = (waiting && tick) ? cnt_inc : cnt;
			wire [sodm_pkg::MS_W-1:0] next_cnt = state_change ? '0 : cnt_run;
			wire drive_change = (next_drive != o_solid_out[c]);
			wire [3:0] settle_inc = settle + 1'b1;
			wire [3:0] settle_run = (tick && !settled) ? settle_inc : settle;
			wire [3:0] next_settle = drive_change ? '0 : settle_run;
			// R11: fault recorded for split channels too
			wire next_fault = o_chan_fault[c] | fb_bad[c];

			// State register
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					state[c] <= sodm_pkg::ST_OFF;
				end else begin
					state[c] <= next_sel;
				end
			end
			// Delay counter, cleared on every state change
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					cnt <= '0;
				end else begin
					cnt <= next_cnt;
				end
			end
			// Drive straight from a flip-flop
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_solid_out[c] <= 1'b0;
				end else begin
					o_solid_out[c] <= next_drive;
				end
			end
			// Settle timer hides the readback lag after a switch
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					settle <= '0;
				end else begin
					settle <= next_settle;
				end
			end
			// Sticky fault, cleared by reset only
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_chan_fault[c] <= 1'b0;
				end else begin
					o_chan_fault[c] <= next_fault;
				end
			end
		end

		genvar p;
		for (p = 0; p < sodm_pkg::NUM_PAIRS; p++) begin : g_pair
			// R11: split channels get no corrective lockout
			wire pair_bad = (fb_bad[2*p] || fb_bad[2*p+1]) && !i_split[p];
			assign chan_lock[2*p] = o_pair_lockout[p];
			assign chan_lock[2*p+1] = o_pair_lockout[p];
			// R10: sticky lockout until reset
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_pair_lockout[p] <= 1'b0;
				end else begin
					o_pair_lockout[p] <= o_pair_lockout[p] | pair_bad;
				end
			end
		end
	endgenerate

	// Relay group: one drive bit, monitored from the internal contact readback
	logic [3:0] relay_settle;
	wire relay_settled = (relay_settle == sodm_pkg::SETTLE_MS);
	// R14: internal readback mismatch
	wire relay_bad = relay_settled && (rb[sodm_pkg::NUM_CHAN] != o_module_relay_out);
	// R13: whole group switched together
	wire next_relay = i_relay_run && !o_relay_lockout && !relay_bad;
	wire next_relay_lock = o_relay_lockout | relay_bad;
	wire relay_change = (next_relay != o_module_relay_out);
	wire [3:0] relay_settle_inc = relay_settle + 1'b1;
	wire [3:0] relay_settle_run = (tick && !relay_settled) ? relay_settle_inc : relay_settle;
	wire [3:0] next_relay_settle = relay_change ? '0 : relay_settle_run;

	// Relay group drive
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_module_relay_out <= 1'b0;
		end else begin
			o_module_relay_out <= next_relay;
		end
	end
	// Sticky relay lockout, cleared by reset only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_relay_lockout <= 1'b0;
		end else begin
			o_relay_lockout <= next_relay_lock;
		end
	end
	// Relay settle timer: contacts get the same SETTLE_MS wait as a solid-state switch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			relay_settle <= '0;
		end else begin
			relay_settle <= next_relay_settle;
		end
	end
	// R7: accepted link reported one cycle late
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_link_active <= 1'b0;
		end else begin
			o_link_active <= link_on;
		end
	end
endmodule : sodm_top
`default_nettype wire

// ---- testbench/sodm_fsd_model.sv ----
// Switching devices whose terminals the block reads back
`timescale 1ns/1ps
`default_nettype none
module sodm_fsd_model (
	input wire logic [3:0] i_drive,
	input wire logic i_relay_drive,
	input wire logic [3:0] i_short,
	input wire logic i_weld,
	output logic [3:0] o_readback_high,
	output logic o_relay_readback
);
	assign o_readback_high = i_drive | i_short;
	assign o_relay_readback = i_relay_drive | i_weld;
endmodule : sodm_fsd_model
`default_nettype wire

// ---- testbench/sodm_props.sv ----
// Assertion checker for the safety output block
`timescale 1ns/1ps
`default_nettype none
module sodm_props (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_run,
	input wire logic [1:0] i_split,
	input wire sodm_pkg::sodm_out_cfg_t [3:0] i_out_cfg,
	input wire logic i_link_en,
	input wire logic [3:0] i_readback_high,
	input wire logic i_relay_run,
	input wire logic i_relay_readback,
	input wire logic [3:0] o_solid_out,
	input wire logic [3:0] o_chan_fault,
	input wire logic [1:0] o_pair_lockout,
	input wire logic o_link_active,
	input wire logic o_module_relay_out,
	input wire logic o_relay_lockout
);
	wire logic link_ok;
	wire logic dly0_on;
	wire logic dly0_off;
	assign dly0_on = i_out_cfg[0].dly == sodm_pkg::DLY_ON;
	assign dly0_off = i_out_cfg[0].dly == sodm_pkg::DLY_OFF;
	// Unused code 3 counts as no delay
	assign link_ok = i_link_en && dly0_off && i_out_cfg[2].dly != sodm_pkg::DLY_ON
		&& i_out_cfg[2].dly != sodm_pkg::DLY_OFF;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_pair_mirror: assert property (!i_split[0] && !$past(i_split[0]) |->
		o_solid_out[1] == o_solid_out[0]) else $error("pair b differs");
	a_off_delay_hold: assert property (dly0_off && $fell(i_run[0]) && o_solid_out[0] |=>
		o_solid_out[0] [*8]) else $error("off delay cut");
	a_on_delay_cancel: assert property (dly0_on && !i_run[0] |=> !o_solid_out[0])
		else $error("on delay kept");
	a_fault_locks_pair: assert property ($rose(o_chan_fault[0]) && !i_split[0] |->
		##[0:1] o_pair_lockout[0]) else $error("no lockout");
	a_lock_forces_off: assert property (o_pair_lockout[0] |=> o_solid_out[1:0] == 2'h0)
		else $error("locked pair on");
	a_split_no_lock: assert property (i_split[1] && $past(i_split[1]) |->
		!$rose(o_pair_lockout[1])) else $error("split pair locked");
	a_relay_group: assert property (!o_relay_lockout ##1 !o_relay_lockout |->
		o_module_relay_out == $past(i_relay_run)) else $error("relay drive wrong");
	a_relay_lock_off: assert property (o_relay_lockout |=> !o_module_relay_out)
		else $error("locked relay on");
	a_link_accept: assert property (1'b1 |=> o_link_active == $past(link_ok))
		else $error("link state wrong");
	c_lockout: cover property (o_pair_lockout[0]);
	c_off_delay: cover property ($fell(o_solid_out[0]) && i_run[0]);
	c_relay_lock: cover property (o_relay_lockout);
endmodule : sodm_props
bind sodm_top sodm_props i_props (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_run(i_run),
	.i_split(i_split),
	.i_out_cfg(i_out_cfg),
	.i_link_en(i_link_en),
	.i_readback_high(i_readback_high),
	.i_relay_run(i_relay_run),
	.i_relay_readback(i_relay_readback),
	.o_solid_out(o_solid_out),
	.o_chan_fault(o_chan_fault),
	.o_pair_lockout(o_pair_lockout),
	.o_link_active(o_link_active),
	.o_module_relay_out(o_module_relay_out),
	.o_relay_lockout(o_relay_lockout)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the safety output block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_run = 4'h0;
	logic [1:0] i_split = 2'h2;
	sodm_pkg::sodm_out_cfg_t [3:0] i_out_cfg = {4{2'h0, 19'h00064}};
	logic i_link_en = 1'b0;
	logic i_relay_run = 1'b0;
	logic [3:0] short = 4'h0;
	logic weld = 1'b0;
	wire logic [3:0] rb, so, cf;
	wire logic [1:0] pl;
	wire logic la, ro, rl, rrb;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 i_clk = ~i_clk;
	// Short ms tick keeps delays near a thousand cycles
	sodm_top #(.CYC_PER_MS(10)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_run(i_run),
		.i_split(i_split), .i_out_cfg(i_out_cfg), .i_link_en(i_link_en),
		.i_readback_high(rb), .i_relay_run(i_relay_run), .i_relay_readback(rrb),
		.o_solid_out(so), .o_chan_fault(cf), .o_pair_lockout(pl), .o_link_active(la),
		.o_module_relay_out(ro), .o_relay_lockout(rl));
	sodm_fsd_model i_fsd (.i_drive(so), .i_relay_drive(ro), .i_short(short), .i_weld(weld),
		.o_readback_high(rb), .o_relay_readback(rrb));
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc_n(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc_n
	task automatic end_sim;
		if (err_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic t_chan;
		i_run = 4'h1;
		cyc_n(2);
		chk("pair", 4'h3, so & 4'h3);
		i_split = 2'h3;
		i_run = 4'h2;
		cyc_n(2);
		chk("split", 4'h2, so & 4'h3);
		i_run = 4'h0;
		i_split = 2'h2;
		i_out_cfg[0].dly = sodm_pkg::DLY_ON;
		cyc_n(2);
		i_run = 4'h1;
		cyc_n(500);
		i_run = 4'h0;
		cyc_n(600);
		chk("on cancel", 4'h0, so & 4'h3);
		i_run = 4'h1;
		cyc_n(995);
		chk("on early", 4'h0, so & 4'h3);
		cyc_n(20);
		chk("on late", 4'h3, so & 4'h3);
		i_run = 4'h0;
		// Let the stop land before the next task changes the delay type
		cyc_n(2);
	endtask : t_chan
	task automatic t_link;
		int n;
		logic bad;
		bad = 1'b0;
		i_out_cfg[0].dly = sodm_pkg::DLY_OFF;
		i_out_cfg[2].dly = sodm_pkg::DLY_ON;
		i_link_en = 1'b1;
		cyc_n(2);
		chk("link refused", 4'h0, {3'h0, la});
		i_out_cfg[2].dly = sodm_pkg::DLY_NONE;
		i_run = 4'h5;
		cyc_n(2);
		chk("link taken", 4'h5, {1'b0, so[2], 1'b0, la});
		i_run = 4'h0;
		cyc_n(10);
		i_run = 4'h5;
		// Input back to run while the delay still counts
		for (n = 10; so[0] === 1'b1 && n < 1100; n++) begin
			bad = bad | (so[2] !== 1'b0);
			cyc_n(1);
		end
		chk("follower", 4'h0, {3'h0, bad});
		chk("off delay", 4'h1, {3'h0, n >= 990 && n < 1100});
		i_out_cfg[0].dly = sodm_pkg::DLY_NONE;
		i_run = 4'h0;
		i_link_en = 1'b0;
		cyc_n(100);
	endtask : t_link
	task automatic t_fault;
		short = 4'h9;
		i_run = 4'h4;
		cyc_n(200);
		chk("lockout", 4'h1, {2'h0, pl});
		chk("faults", 4'h9, cf);
		i_run = 4'h5;
		cyc_n(3);
		chk("forced off", 4'h4, so);
		i_relay_run = 1'b1;
		cyc_n(2);
		chk("relay on", 4'h1, {3'h0, ro});
		i_relay_run = 1'b0;
		weld = 1'b1;
		cyc_n(200);
		i_relay_run = 1'b1;
		cyc_n(2);
		chk("relay lock", 4'h2, {2'h0, rl, ro});
	endtask : t_fault
	initial begin
		cyc_n(8);
		i_rst_n = 1'b1;
		cyc_n(1);
		t_chan();
		t_link();
		t_fault();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
